/* File: hdl/bib_regs_consts.svh */
// constants for the bus information block register bank
`ifndef BIB_REGS_CONSTS_SVH
`define BIB_REGS_CONSTS_SVH
`define BIB_ADDR_W 8
`define BIB_OPT_OFFSET 8'h20
`define BIB_UID_OFFSET 8'h24
`define BIB_STAT_OFFSET 8'h2C
`define BIB_LOAD_OFFSET 8'h30
`define BIB_OPT_RMC_BIT 31
`define BIB_OPT_CMC_BIT 30
`define BIB_OPT_ISC_BIT 29
`define BIB_OPT_BMC_BIT 28
`define BIB_OPT_PMC_BIT 27
`define BIB_OPT_ACC_HI 23
`define BIB_OPT_ACC_LO 16
`define BIB_OPT_MREQ_HI 15
`define BIB_OPT_MREQ_LO 12
`define BIB_OPT_GEN_HI 7
`define BIB_OPT_GEN_LO 6
`define BIB_OPT_SPD_HI 2
`define BIB_OPT_SPD_LO 0
`define BIB_OPT_WMASK 32'hF8FFF0C0
`define BIB_SPD_CODE 3'h2
`define BIB_MREQ_RESET 4'hA
`define BIB_MREQ_MIN 4'h8
`define BIB_UID_RESET 32'h00000000
`endif

/* File: hdl/bib_regs_pkg.sv */
// types for the bus information block register bank
package bib_regs_pkg;
  typedef logic [31:0] bib_word_t;
  typedef logic [7:0] bib_addr_t;
  typedef enum logic [1:0] {
    BIB_UID_OPEN = 2'b00,
    BIB_UID_LOCKED = 2'b01
  } bib_uid_state_e;
endpackage

/* File: hdl/bib_regs.sv */
// bus options and upper identifier register bank
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`include "bib_regs_consts.svh"
module bib_regs (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic soft_rst_in,
  input wire logic host_bus_rst_in,
  input wire logic eeprom_present_in,
  input wire logic eeprom_load_in,
  input wire bib_regs_pkg::bib_word_t eeprom_data_in,
  input wire bib_regs_pkg::bib_addr_t addr_in,
  input wire bib_regs_pkg::bib_word_t wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic link_active_bit_in,
  input wire logic rx_blk_wr_in,
  input wire logic [15:0] rx_blk_len_in,
  output bib_regs_pkg::bib_word_t rdata_out,
  output logic [31:0] unique_identifier_out,
  output logic uid_locked_out,
  output logic ack_type_error_out
);
  import bib_regs_pkg::*;

  bib_word_t opt_reg;
  bib_word_t uid_reg;
  bib_uid_state_e uid_state_reg;
  logic locked_reg;
  bib_word_t rdata_reg;
  logic ack_err_reg;
  logic rst_s1_reg;
  logic rst_s2_reg;
  logic rst_s3_reg;
  logic ee_s1_reg;
  logic ee_s2_reg;
  logic ld_s1_reg;
  logic ld_s2_reg;
  logic link_s1_reg;
  logic link_s2_reg;
  logic bus_rst_pulse;
  logic fw_load;
  logic ee_load;
  bib_word_t opt_view;
  bib_word_t opt_next;

  // byte count for a max request code
  function automatic logic [16:0] mreq_bytes(input logic [3:0] code);
    mreq_bytes = 17'h00001 << (5'(code) + 5'h01);
  endfunction

  // pins cross into the system clock
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
      rst_s3_reg <= 1'b0;
      ee_s1_reg <= 1'b0;
      ee_s2_reg <= 1'b0;
      ld_s1_reg <= 1'b0;
      ld_s2_reg <= 1'b0;
      link_s1_reg <= 1'b0;
      link_s2_reg <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= host_bus_rst_in;
      rst_s2_reg <= rst_s1_reg;
      rst_s3_reg <= rst_s2_reg;
      ee_s1_reg <= eeprom_present_in;
      ee_s2_reg <= ee_s1_reg;
      ld_s1_reg <= eeprom_load_in;
      ld_s2_reg <= ld_s1_reg;
      link_s1_reg <= link_active_bit_in;
      link_s2_reg <= link_s1_reg;
    end
  end

  assign bus_rst_pulse = rst_s2_reg && !rst_s3_reg;
  assign ee_load = ee_s2_reg && ld_s2_reg;
  assign fw_load = !ee_s2_reg && wr_in && (addr_in == `BIB_LOAD_OFFSET);

  always_comb
  begin
    opt_view = opt_reg & `BIB_OPT_WMASK;
    opt_view[`BIB_OPT_SPD_HI:`BIB_OPT_SPD_LO] = `BIB_SPD_CODE;
  end

  always_comb
  begin
    opt_next = opt_reg;
    if (wr_in && addr_in == `BIB_OPT_OFFSET)
    begin
      opt_next = wdata_in & `BIB_OPT_WMASK;
      if (wdata_in[`BIB_OPT_MREQ_HI:`BIB_OPT_MREQ_LO] < `BIB_MREQ_MIN)
      begin
        opt_next[`BIB_OPT_MREQ_HI:`BIB_OPT_MREQ_LO] = opt_reg[`BIB_OPT_MREQ_HI:`BIB_OPT_MREQ_LO];
      end
    end
  end

  // hard reset value of max request
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      opt_reg <= {16'h0000, `BIB_MREQ_RESET, 12'h000};
    end
    else if (soft_rst_in)
    begin
      opt_reg <= opt_reg & {16'h0000, 4'hF, 12'h000};
    end
    else
    begin
      opt_reg <= opt_next;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      uid_reg <= `BIB_UID_RESET;
      uid_state_reg <= BIB_UID_LOCKED;
    end
    else if (bus_rst_pulse)
    begin
      uid_state_reg <= BIB_UID_OPEN;
    end
    else
    begin
      case (uid_state_reg)
        BIB_UID_OPEN:
        begin
          if (ee_load)
          begin
            uid_reg <= eeprom_data_in;
            uid_state_reg <= BIB_UID_LOCKED;
          end
          else if (fw_load)
          begin
            uid_reg <= wdata_in;
            uid_state_reg <= BIB_UID_LOCKED;
          end
        end
        BIB_UID_LOCKED:
        begin
          uid_state_reg <= BIB_UID_LOCKED;
        end
        default:
        begin
          uid_state_reg <= BIB_UID_LOCKED;
        end
      endcase
    end
  end

  // lock flag kept as a flop for the output
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      locked_reg <= 1'b1;
    end
    else if (bus_rst_pulse)
    begin
      locked_reg <= 1'b0;
    end
    else if (uid_state_reg != BIB_UID_LOCKED)
    begin
      locked_reg <= (uid_state_reg != BIB_UID_OPEN) || ee_load || fw_load;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      rdata_reg <= 32'h00000000;
    end
    else if (rd_in)
    begin
      case (addr_in)
        `BIB_OPT_OFFSET: rdata_reg <= opt_view;
        `BIB_UID_OFFSET: rdata_reg <= uid_reg;
        `BIB_STAT_OFFSET: rdata_reg <= {29'h00000000, link_s2_reg, ee_s2_reg, uid_state_reg == BIB_UID_LOCKED};
        default: rdata_reg <= 32'h00000000;
      endcase
    end
    else
    begin
      rdata_reg <= 32'h00000000;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      ack_err_reg <= 1'b0;
    end
    else
    begin
      ack_err_reg <= rx_blk_wr_in && ({1'b0, rx_blk_len_in} > mreq_bytes(opt_reg[`BIB_OPT_MREQ_HI:`BIB_OPT_MREQ_LO]));
    end
  end

  assign rdata_out = rdata_reg;
  assign unique_identifier_out = uid_reg;
  assign uid_locked_out = locked_reg;
  assign ack_type_error_out = ack_err_reg;

  sequence open_seq;
    uid_state_reg == BIB_UID_OPEN && fw_load && !ee_load;
  endsequence

  sequence bus_rst_seq;
    rst_s2_reg && !rst_s3_reg;
  endsequence

  // rsvd read zero
  rsvd_zero_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    $past(rd_in) && $past(addr_in) == `BIB_OPT_OFFSET |-> (rdata_out & 32'h07000F38) == 32'h00000000)
    else $error("reserved option bits not zero");
  speed_code_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    rd_in && addr_in == `BIB_OPT_OFFSET |=> rdata_out[2:0] == 3'h2)
    else $error("speed code not 010");
  mreq_reset_a: assert property (@(posedge clk_sys_in)
    srst_in |=> opt_reg[15:12] == 4'hA && uid_reg == 32'h00000000)
    else $error("hard reset values wrong");
  mreq_floor_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    opt_reg[15:12] >= 4'h8)
    else $error("max request below 512 bytes");
  soft_keep_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    soft_rst_in |=> $stable(opt_reg[15:12]))
    else $error("soft reset changed max request");
  fw_lock_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    open_seq and !bus_rst_pulse |=> uid_locked_out && uid_reg == $past(wdata_in))
    else $error("firmware load did not lock");
  locked_hold_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    uid_locked_out && !bus_rst_pulse |=> $stable(uid_reg))
    else $error("locked identifier changed");
  ee_lock_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    uid_state_reg == BIB_UID_OPEN && ee_load && !bus_rst_pulse |=> uid_locked_out ##0 uid_reg == $past(eeprom_data_in))
    else $error("eeprom load did not lock");
  pmc_write_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    wr_in && addr_in == `BIB_OPT_OFFSET && !soft_rst_in |=> opt_reg[31:27] == $past(wdata_in[31:27]))
    else $error("capability bits not written");
  bus_reopen_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    bus_rst_seq |=> !uid_locked_out)
    else $error("host bus reset did not reopen identifier");
  id_readonly_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    !fw_load && !ee_load |=> $stable(uid_reg))
    else $error("identifier changed without a load");
  ee_block_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    ee_s2_reg && !ee_load |=> $stable(uid_reg))
    else $error("firmware changed identifier with eeprom present");
  ack_idle_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    !rx_blk_wr_in |=> !ack_type_error_out)
    else $error("type error flag without block write");
  rdata_idle_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    !rd_in |=> rdata_out == 32'h00000000)
    else $error("read data not zero when idle");
  lock_flag_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    uid_locked_out == (uid_state_reg == BIB_UID_LOCKED))
    else $error("lock flag differs from lock state");
  soft_clear_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    soft_rst_in |=> (opt_reg & 32'hFFFF0FFF) == 32'h00000000)
    else $error("soft reset left option fields set");
  acc_write_a: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    wr_in && addr_in == `BIB_OPT_OFFSET && !soft_rst_in |=> opt_reg[23:16] == $past(wdata_in[23:16]))
    else $error("accuracy field not written");
endmodule // bib_regs

/* File: test/bib_eeprom_model.sv */
// serial eeprom loader model that hands the identifier word to the bank
`timescale 1ns/1ps
module bib_eeprom_model #(
  // arbitrary value
  parameter logic [31:0] UID_WORD = 32'h5A5A0001
) (
  input wire logic clk_sys_in,
  input wire logic present_in,
  input wire logic go_in,
  output logic eeprom_present_out,
  output logic eeprom_load_out,
  output logic [31:0] eeprom_data_out
);
  logic [2:0] cnt_reg = 3'h0;
  assign eeprom_present_out = present_in;
  always_ff @(posedge clk_sys_in)
  begin
    if (go_in && present_in)
      cnt_reg <= 3'h6;
    else if (cnt_reg != 3'h0)
      cnt_reg <= cnt_reg - 3'h1;
  end
  assign eeprom_load_out = (cnt_reg != 3'h0);
  // data only valid while loading
  assign eeprom_data_out = eeprom_load_out ? UID_WORD : ~UID_WORD;
endmodule // bib_eeprom_model

/* File: test/bib_regs_tb.sv */
// self-checking bench for the bus information block registers
`timescale 1ns/1ps
module bib_regs_tb;
  import bib_regs_pkg::*;
  logic clk_sys_in = 1'b0, srst_in = 1'b1, soft_rst_in = 1'b0, host_bus_rst_in = 1'b0;
  logic present = 1'b0, ld_go = 1'b0, eeprom_present_in, eeprom_load_in;
  logic wr_in = 1'b0, rd_in = 1'b0, link_active_bit_in = 1'b1, rx_blk_wr_in = 1'b0;
  logic [15:0] rx_blk_len_in = 16'h0000;
  bib_word_t eeprom_data_in, wdata_in = 32'h0, rdata_out, unique_identifier_out, v, fw, d;
  bib_addr_t addr_in = 8'h00;
  logic uid_locked_out, ack_type_error_out;
  logic [31:0] seed = 32'hDDECE692;
  logic [3:0] mreq = 4'hA;
  int n_fail = 0, check_count = 0;
  bib_regs u_dut (.clk_sys_in, .srst_in, .soft_rst_in, .host_bus_rst_in, .eeprom_present_in, .eeprom_load_in,
    .eeprom_data_in, .addr_in, .wdata_in, .wr_in, .rd_in, .link_active_bit_in, .rx_blk_wr_in, .rx_blk_len_in,
    .rdata_out, .unique_identifier_out, .uid_locked_out, .ack_type_error_out);
  bib_eeprom_model u_rom (.clk_sys_in, .present_in(present), .go_in(ld_go),
    .eeprom_present_out(eeprom_present_in), .eeprom_load_out(eeprom_load_in), .eeprom_data_out(eeprom_data_in));
  initial
  begin
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [31:0] opt_exp(input logic [31:0] w, input logic [3:0] m);
    return (w & 32'hF8FF00C0) | {16'h0, m, 12'h002};
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input bib_addr_t a, input bib_word_t w);
    @(posedge clk_sys_in);
    addr_in <= a;
    wdata_in <= w;
    wr_in <= 1'b1;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input bib_addr_t a, output bib_word_t r);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1;
    r = rdata_out;
  endtask
  task automatic blk(input logic [15:0] len, input logic e);
    @(posedge clk_sys_in);
    rx_blk_wr_in <= 1'b1;
    rx_blk_len_in <= len;
    @(posedge clk_sys_in);
    rx_blk_wr_in <= 1'b0;
    #1;
    chk({31'h0, ack_type_error_out}, {31'h0, e});
  endtask
  task automatic wait_lock(input logic e);
    for (int i = 0; i < 40 && uid_locked_out !== e; i++)
    begin
      @(posedge clk_sys_in);
      #1;
    end
    if (uid_locked_out !== e)
    begin
      n_fail++;
      print_verdict();
    end
  endtask
  task automatic hbr();
    @(posedge clk_sys_in);
    host_bus_rst_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    host_bus_rst_in <= 1'b0;
    wait_lock(1'b0);
  endtask
  initial
  begin
    repeat (12) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    rd(8'h20, v);
    chk(v, 32'h0000A002);
    @(posedge clk_sys_in);
    #1;
    chk(rdata_out, 32'h0);
    rd(8'h24, v);
    chk(v, 32'h0);
    for (int i = 0; i < 12; i++)
    begin
      seed = xs(seed);
      d = seed;
      if (i < 2)
        d[15:12] = 4'h7 + i[3:0];
      d[7:6] = i[1:0];
      wr(8'h20, d);
      if (d[15:12] >= 4'h8)
        mreq = d[15:12];
      rd(8'h20, v);
      chk(v, opt_exp(d, mreq));
    end
    @(posedge clk_sys_in);
    soft_rst_in <= 1'b1;
    @(posedge clk_sys_in);
    soft_rst_in <= 1'b0;
    rd(8'h20, v);
    chk(v, opt_exp(32'h0, mreq));
    for (int c = 8; c < 15; c++)
    begin
      wr(8'h20, {16'h0, c[3:0], 12'h0});
      blk(16'h1 << (c + 1), 1'b0);
      blk((16'h1 << (c + 1)) + 16'h1, 1'b1);
    end
    wr(8'h24, seed);
    rd(8'h24, v);
    chk(v, 32'h0);
    hbr();
    fw = xs(seed);
    wr(8'h30, fw);
    wait_lock(1'b1);
    rd(8'h24, v);
    chk(v, fw);
    rd(8'h2C, v);
    chk(v, 32'h5);
    wr(8'h30, ~fw);
    wr(8'h24, ~fw);
    rd(8'h24, v);
    chk(v, fw);
    @(posedge clk_sys_in);
    present <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    hbr();
    @(posedge clk_sys_in);
    ld_go <= 1'b1;
    @(posedge clk_sys_in);
    ld_go <= 1'b0;
    wait_lock(1'b1);
    wr(8'h30, fw);
    rd(8'h24, v);
    chk(v, 32'h5A5A0001);
    chk(unique_identifier_out, 32'h5A5A0001);
    rd(8'h2C, v);
    chk(v, 32'h7);
    @(posedge clk_sys_in);
    link_active_bit_in <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    rd(8'h2C, v);
    chk(v, 32'h3);
    print_verdict();
  end
endmodule // bib_regs_tb
